// file: nvac_pkg.sv
// Purpose: Constants for the nonvolatile data store access controller.
// Assumes: One system clock at 10 MHz.
// Notes: Register offsets are byte addresses within each data-memory bank.
package nvac_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] NVAC_CONTROL_OFFSET = 8'h40;
    localparam logic [7:0] NVAC_CONTROL_BANK = 8'h01;
    localparam logic [7:0] NVAC_ADDRESS_OFFSET = 8'h1E;
    localparam logic [7:0] NVAC_DATA_OFFSET = 8'h1F;
    localparam logic [7:0] NVAC_DIRECT_BANK = 8'h00;
    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int NVAC_BIT_WRITE_PERMIT = 3;
    localparam int NVAC_BIT_WRITE_START = 2;
    localparam int NVAC_BIT_READ_PERMIT = 1;
    localparam int NVAC_BIT_READ_START = 0;
    localparam logic [4:0] NVAC_ADDRESS_RESET = 5'h00;
    localparam logic [7:0] NVAC_DATA_RESET = 8'h00;
    localparam logic [3:0] NVAC_CONTROL_RESET = 4'h0;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int NVAC_CLK_PERIOD_NS = 100;
    localparam int NVAC_WRITE_TIME_NS = 2000;
    localparam int NVAC_READ_TIME_NS = 400;
    localparam int NVAC_WRITE_CYCLES = (NVAC_WRITE_TIME_NS + NVAC_CLK_PERIOD_NS - 1) / NVAC_CLK_PERIOD_NS;
    localparam int NVAC_READ_CYCLES = (NVAC_READ_TIME_NS + NVAC_CLK_PERIOD_NS - 1) / NVAC_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        NVAC_IDLE = 2'b00,
        NVAC_READ = 2'b01,
        NVAC_WRITE = 2'b10
    } nvac_state_type;
endpackage : nvac_pkg

// file: nvac_store.sv
// Purpose: Byte array of the nonvolatile data store.
// Assumes: Write and read commands come from the controller on the same clock.
// Notes: Read data is registered one cycle after the read strobe.
`timescale 1ns/1ps
module nvac_store #(
    parameter int DEPTH = 32
) (
    // Clock
    input wire logic core_clk_i,
    // Access
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [$clog2(DEPTH)-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_q [DEPTH];

    if (DEPTH < 2) begin : g_bad_depth
        $error("DEPTH must be at least 2.");
    end

    always_ff @(posedge core_clk_i) begin
        if (wr_i) begin
            mem_q[addr_i] <= wdata_i;
        end
        if (rd_i) begin
            rdata_o <= mem_q[addr_i];
        end
    end
endmodule : nvac_store

// file: nvac_ctrl.sv
// Purpose: Access controller for a 32 by 8 nonvolatile data store.
// Assumes: CPU special function register port, one system clock, async reset.
// Notes: Write and read durations are counted in system clocks.
`timescale 1ns/1ps
module nvac_ctrl
    import nvac_pkg::*;
#(
    parameter int DEPTH = 32,
    parameter int WRITE_CYCLES = NVAC_WRITE_CYCLES,
    parameter int READ_CYCLES = NVAC_READ_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Special function register port
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] bank_select_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    // Completion
    output logic nv_done_flag_set_o,
    output logic busy_o
);
    localparam int CW = $clog2((WRITE_CYCLES > READ_CYCLES ? WRITE_CYCLES : READ_CYCLES) + 1);

    if (DEPTH != 32 || WRITE_CYCLES < 1 || READ_CYCLES < 1) begin : g_bad_params
        $error("Unsupported parameter values.");
    end

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic sel_addr, sel_data, sel_ctrl;
    always_comb begin
        sel_addr = (bank_select_i == NVAC_DIRECT_BANK) && (sfr_addr_i == NVAC_ADDRESS_OFFSET);
        sel_data = (bank_select_i == NVAC_DIRECT_BANK) && (sfr_addr_i == NVAC_DATA_OFFSET);
        sel_ctrl = (bank_select_i == NVAC_CONTROL_BANK) && (sfr_addr_i == NVAC_CONTROL_OFFSET);
    end

    // ----------------------------------------
    // Registers and sequencer
    // ----------------------------------------
    logic [4:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic wperm_q, wperm_d, wstart_q, wstart_d, rperm_q, rperm_d, rstart_q, rstart_d;
    nvac_state_type state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic load_q, load_d, done_q, done_d;
    logic st_wr, st_rd;
    logic [7:0] rdata;

    always_comb begin
        addr_d = addr_q;
        data_d = data_q;
        wperm_d = wperm_q;
        wstart_d = wstart_q;
        rperm_d = rperm_q;
        rstart_d = rstart_q;
        state_d = state_q;
        cnt_d = cnt_q;
        load_d = 1'b0;
        done_d = 1'b0;
        st_wr = 1'b0;
        st_rd = 1'b0;
        if (sfr_wr_i && sel_addr) begin
            addr_d = sfr_wdata_i[4:0];
        end
        if (sfr_wr_i && sel_data) begin
            data_d = sfr_wdata_i;
        end
        if (load_q) begin
            data_d = rdata;
        end
        if (sfr_wr_i && sel_ctrl) begin
            wperm_d = sfr_wdata_i[NVAC_BIT_WRITE_PERMIT];
            rperm_d = sfr_wdata_i[NVAC_BIT_READ_PERMIT];
            if (state_q == NVAC_IDLE && !load_q) begin
                // Start only with permit already set beforehand and no cycle still finishing.
                if (sfr_wdata_i[NVAC_BIT_WRITE_START] && wperm_q) begin
                    wstart_d = 1'b1;
                    state_d = NVAC_WRITE;
                    cnt_d = CW'(WRITE_CYCLES);
                end else if (sfr_wdata_i[NVAC_BIT_READ_START] && rperm_q) begin
                    rstart_d = 1'b1;
                    state_d = NVAC_READ;
                    cnt_d = CW'(READ_CYCLES);
                end
            end
        end
        unique case (state_q)
            NVAC_IDLE: begin
            end
            NVAC_WRITE: begin
                cnt_d = cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    st_wr = 1'b1;
                    wstart_d = 1'b0;
                    done_d = 1'b1;
                    state_d = NVAC_IDLE;
                end
            end
            NVAC_READ: begin
                cnt_d = cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    st_rd = 1'b1;
                    load_d = 1'b1;
                    state_d = NVAC_IDLE;
                end
            end
            default: begin
                state_d = NVAC_IDLE;
            end
        endcase
        if (load_q) begin
            rstart_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_q <= NVAC_ADDRESS_RESET;
            data_q <= NVAC_DATA_RESET;
            wperm_q <= NVAC_CONTROL_RESET[NVAC_BIT_WRITE_PERMIT];
            wstart_q <= NVAC_CONTROL_RESET[NVAC_BIT_WRITE_START];
            rperm_q <= NVAC_CONTROL_RESET[NVAC_BIT_READ_PERMIT];
            rstart_q <= NVAC_CONTROL_RESET[NVAC_BIT_READ_START];
            state_q <= NVAC_IDLE;
            cnt_q <= '0;
            load_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            data_q <= data_d;
            wperm_q <= wperm_d;
            wstart_q <= wstart_d;
            rperm_q <= rperm_d;
            rstart_q <= rstart_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            load_q <= load_d;
            done_q <= done_d;
        end
    end

    // ----------------------------------------
    // Store
    // ----------------------------------------
    nvac_store #(.DEPTH(DEPTH)) u_store (
        .core_clk_i(core_clk_i),
        .wr_i(st_wr),
        .rd_i(st_rd),
        .addr_i(addr_q),
        .wdata_i(data_q),
        .rdata_o(rdata)
    );

    // ----------------------------------------
    // Read back
    // ----------------------------------------
    always_comb begin
        sfr_hit_o = sel_addr || sel_data || sel_ctrl;
        sfr_rdata_o = 8'h00;
        if (sfr_rd_i && sel_addr) begin
            sfr_rdata_o = {3'h0, addr_q};
        end else if (sfr_rd_i && sel_data) begin
            sfr_rdata_o = data_q;
        end else if (sfr_rd_i && sel_ctrl) begin
            sfr_rdata_o = {4'h0, wperm_q, wstart_q, rperm_q, rstart_q};
        end
        nv_done_flag_set_o = done_q;
        busy_o = wstart_q || rstart_q;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_write_go;
        state_q == NVAC_IDLE && !load_q && sfr_wr_i && sel_ctrl && sfr_wdata_i[NVAC_BIT_WRITE_START] && wperm_q;
    endsequence

    a_write_refused: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_q == NVAC_IDLE && !wperm_q && !(sfr_wr_i && sel_ctrl && sfr_wdata_i[0] && rperm_q))
        |=> state_q == NVAC_IDLE) else $error("Write started without permit.");
    a_write_start: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        s_write_go |=> wstart_q && state_q == NVAC_WRITE) else $error("Write start not taken.");
    a_write_length: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        s_write_go |-> ##WRITE_CYCLES wstart_q ##1 !wstart_q) else $error("Write start bit not cleared on time.");
    a_busy_ignored: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        busy_o |=> !$rose(wstart_q) && !$rose(rstart_q)) else $error("Start taken while busy.");
    a_write_done: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $fell(wstart_q) |-> nv_done_flag_set_o) else $error("Done flag missing at write end.");
    a_write_nonzero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        s_write_go |=> wstart_q ##1 1'b1) else $error("Write completed instantly.");
    a_read_refused: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $rose(rstart_q) |-> $past(rperm_q)) else $error("Read started without permit.");
    a_read_load: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $fell(rstart_q) |-> $past(load_q)) else $error("Read start cleared before data load.");
    a_ctrl_upper: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        sfr_rd_i && sel_ctrl |-> sfr_rdata_o[7:4] == 4'h0) else $error("Control upper bits not zero.");
    a_addr_upper: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        sfr_rd_i && sel_addr |-> sfr_rdata_o[7:5] == 3'h0) else $error("Address upper bits not zero.");
    a_one_cycle: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !(wstart_q && rstart_q)) else $error("Write and read active together.");
endmodule : nvac_ctrl

// file: tb_eeprom_data_access_ctrl.sv
// Purpose: Self-checking bench for the nonvolatile store access controller.
// Assumes: Shortened write and read counts set through parameters.
// Notes: Expected values follow the register map and control bit positions.
`timescale 1ns/1ps
module tb_eeprom_data_access_ctrl
    import nvac_pkg::*;
;
    localparam int WR_CYC = 3;
    localparam int RD_CYC = 2;
    localparam logic [7:0] CB = NVAC_CONTROL_BANK;
    localparam logic [7:0] CO = NVAC_CONTROL_OFFSET;
    localparam logic [7:0] DB = NVAC_DIRECT_BANK;
    localparam logic [7:0] AO = NVAC_ADDRESS_OFFSET;
    localparam logic [7:0] DO = NVAC_DATA_OFFSET;
    typedef struct {
        logic w;
        logic [7:0] bank;
        logic [7:0] addr;
        logic [7:0] wd;
        logic [7:0] exp;
        logic hit;
    } nvac_row_type;
    logic core_clk_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic sfr_wr_i = 1'h0;
    logic sfr_rd_i = 1'h0;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] bank_select_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [7:0] sfr_rdata_o;
    logic sfr_hit_o;
    logic nv_done_flag_set_o;
    logic busy_o;
    int n_mismatch = 0;
    int compares = 0;
    int n;
    int pulses;
    nvac_row_type rows [9] = '{
        '{1'h0, DB, AO, 8'h00, 8'h00, 1'h1},
        '{1'h0, DB, DO, 8'h00, 8'h00, 1'h1},
        '{1'h0, CB, CO, 8'h00, 8'h00, 1'h1},
        '{1'h1, DB, AO, 8'hFF, 8'h1F, 1'h1},
        '{1'h1, DB, DO, 8'hA5, 8'hA5, 1'h1},
        '{1'h0, DB, CO, 8'h00, 8'h00, 1'h0},
        '{1'h0, CB, AO, 8'h00, 8'h00, 1'h0},
        '{1'h1, CB, CO, 8'hF2, 8'h02, 1'h1},
        '{1'h1, CB, CO, 8'h00, 8'h00, 1'h1}
    };

    nvac_ctrl #(.DEPTH(32), .WRITE_CYCLES(WR_CYC), .READ_CYCLES(RD_CYC)) dut (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_addr_i(sfr_addr_i), .bank_select_i(bank_select_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o), .nv_done_flag_set_o(nv_done_flag_set_o),
        .busy_o(busy_o)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] bank, input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk_i);
        sfr_wr_i <= 1'h1;
        bank_select_i <= bank;
        sfr_addr_i <= addr;
        sfr_wdata_i <= data;
        @(posedge core_clk_i);
        sfr_wr_i <= 1'h0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] bank, input logic [7:0] addr, input logic [7:0] exp, input logic hit);
        @(posedge core_clk_i);
        sfr_rd_i <= 1'h1;
        bank_select_i <= bank;
        sfr_addr_i <= addr;
        #10;
        check("read data", exp, sfr_rdata_o);
        check("hit", {7'h00, hit}, {7'h00, sfr_hit_o});
        @(posedge core_clk_i);
        sfr_rd_i <= 1'h0;
    endtask : rd_reg

    // Counts edges until busy falls and the done pulses seen meanwhile.
    task automatic wait_idle;
        n = 0;
        pulses = 0;
        do begin
            @(posedge core_clk_i);
            n++;
            #10;
            if (nv_done_flag_set_o === 1'h1) pulses++;
        end while (busy_o !== 1'h0 && n < 50);
    endtask : wait_idle

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end

    initial begin
        #(3000 * 100);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge core_clk_i);
        reset_n_i <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].bank, rows[i].addr, rows[i].wd);
            rd_reg(rows[i].bank, rows[i].addr, rows[i].exp, rows[i].hit);
        end
        $display("register table done");
        wr_reg(CB, CO, 8'h04);
        wait_idle();
        check("refused write", 8'h01, 8'(n));
        check("refused pulses", 8'h00, 8'(pulses));
        wr_reg(CB, CO, 8'h0C);
        wait_idle();
        check("same write permit", 8'h01, 8'(n));
        rd_reg(CB, CO, 8'h08, 1'h1);
        $display("write refusal done");
        wr_reg(DB, AO, 8'h05);
        wr_reg(DB, DO, 8'h3C);
        wr_reg(CB, CO, 8'h08);
        wr_reg(CB, CO, 8'h0C);
        wait_idle();
        check("write cycles", 8'(WR_CYC), 8'(n));
        check("done pulses", 8'h01, 8'(pulses));
        rd_reg(CB, CO, 8'h08, 1'h1);
        wr_reg(DB, AO, 8'h1F);
        wr_reg(DB, DO, 8'h81);
        wr_reg(CB, CO, 8'h08);
        wr_reg(CB, CO, 8'h0C);
        wr_reg(CB, CO, 8'h0B);
        wait_idle();
        check("second write", 8'(WR_CYC - 2), 8'(n));
        check("second done pulses", 8'h01, 8'(pulses));
        rd_reg(CB, CO, 8'h0A, 1'h1);
        $display("write cycles done");
        wr_reg(DB, DO, 8'h00);
        wr_reg(DB, AO, 8'h05);
        wr_reg(CB, CO, 8'h02);
        wr_reg(CB, CO, 8'h03);
        wait_idle();
        check("read cycles", 8'(RD_CYC + 1), 8'(n));
        rd_reg(DB, DO, 8'h3C, 1'h1);
        wr_reg(DB, AO, 8'h1F);
        wr_reg(CB, CO, 8'h03);
        wait_idle();
        rd_reg(DB, DO, 8'h81, 1'h1);
        wr_reg(CB, CO, 8'h00);
        wr_reg(CB, CO, 8'h01);
        wait_idle();
        check("refused read", 8'h01, 8'(n));
        rd_reg(DB, DO, 8'h81, 1'h1);
        $display("read cycles done");
        wr_reg(CB, CO, 8'h08);
        wr_reg(CB, CO, 8'h0C);
        @(posedge core_clk_i);
        reset_n_i <= 1'h0;
        @(posedge core_clk_i);
        #10;
        check("busy in reset", 8'h00, {7'h00, busy_o});
        @(posedge core_clk_i);
        reset_n_i <= 1'h1;
        rd_reg(CB, CO, 8'h00, 1'h1);
        rd_reg(DB, AO, 8'h00, 1'h1);
        rd_reg(DB, DO, 8'h00, 1'h1);
        $display("mid write reset done");
        wrap_up();
    end
endmodule : tb_eeprom_data_access_ctrl
